// *** src/uism_regs.vh ***
/*
 * register offsets, field positions, reset values and timing counts for the
 * serial channel interrupt, sleep and modem control block.
 * assumes a 32-bit apb bus with byte addresses; each register is one word.
 */
// Contract
// R01 - normal mode: line errors raise level one
// R02 - nine-bit mode: separate error and address masks
// R03 - rx level above trigger raises 2a
// R04 - four idle character periods raise 2b
// R05 - tx level below trigger raises level three
// R06 - trigger zero waits for fully idle transmitter
// R07 - modem deltas raise level four, msr read clears
// R08 - enhanced xoff or special match raises five
// R09 - cts or rts rising raises level six; code raises it in enhanced mode only
// R10 - sleep only when channel fully quiet
// R11 - sleep bit reads back actual sleep state
// R12 - wake when any condition fails or cleared
// R13 - no sleep in infrared mode
// R14 - dtr and rts pins are active low
// R15 - general outputs follow control bits two, three
// R16 - loopback routes outputs back to inputs
// R17 - interrupts keep working during loopback
// R18 - bit five: xon-any or hardware flow
// R19 - bit six selects infrared in enhanced mode
// R20 - bit seven selects prescaler, enhanced writes only
// R21 - modem delta flags, ring on trailing edge
// R22 - status high nibble is inverted modem inputs
// R23 - ident shows highest pending level code
`ifndef UISM_REGS_VH
`define UISM_REGS_VH

// ------------------------------
// register byte offsets
// ------------------------------
`define UISM_OFF_IER      8'h04
`define UISM_OFF_ISR      8'h08
`define UISM_OFF_MCR      8'h10
`define UISM_OFF_LSR      8'h14
`define UISM_OFF_MSR      8'h18
`define UISM_OFF_EFR      8'h20
`define UISM_OFF_ACR      8'h24
`define UISM_OFF_NMR      8'h28
`define UISM_OFF_CPR      8'h2C
`define UISM_OFF_CFG      8'h30
`define UISM_OFF_RTL      8'h34
`define UISM_OFF_TTL      8'h38

// ------------------------------
// field positions
// ------------------------------
`define UISM_IER_RDA      0
`define UISM_IER_THR      1
`define UISM_IER_RLS      2
`define UISM_IER_MS       3
`define UISM_IER_SLEEP    4
`define UISM_IER_SPEC     5
`define UISM_IER_RTS      6
`define UISM_IER_CTS      7
`define UISM_MCR_LOOP     4
`define UISM_MCR_XANY     5
`define UISM_MCR_IRDA     6
`define UISM_MCR_PRESC    7
`define UISM_EFR_ENH      4
`define UISM_EFR_SPEC     5
`define UISM_ACR_TRIG     5
`define UISM_NMR_NINE     0
`define UISM_NMR_ADDR     1
`define UISM_CFG_FIFO     0

// ------------------------------
// reset values, identification codes, timing
// ------------------------------
`define UISM_CPR_RESET    8'h20
`define UISM_ID_NONE      6'h01
`define UISM_ID_RLS       6'h06
`define UISM_ID_RDA       6'h04
`define UISM_ID_TOUT      6'h0C
`define UISM_ID_THR       6'h02
`define UISM_ID_MS        6'h00
`define UISM_ID_SPEC      6'h10
`define UISM_ID_CTSRTS    6'h20
`define UISM_TOUT_CHARS   3'h4

`endif

// *** src/uism_ctrl.v ***
/*
 * interrupt source generation and priority, sleep control, modem control
 * and modem status for one serial channel, with an apb register slave.
 * assumes the fifos, shifters and baud logic sit outside and report their
 * levels and events here as pulses synchronous to pclk.
 */
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "uism_regs.vh"

module uism_ctrl #(
  parameter LVL_W = 8
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [LVL_W-1:0] rx_level,
  input  wire [LVL_W-1:0] tx_level,
  input  wire             rx_push,
  input  wire             rx_read,
  input  wire             char_tick,
  input  wire             rx_idle,
  input  wire             tx_shift_empty,
  input  wire             overrun_evt,
  input  wire             parity_evt,
  input  wire             framing_evt,
  input  wire             break_evt,
  input  wire             xoff_evt,
  input  wire             second_stop_char_evt,
  input  wire             special_evt,
  input  wire             tx_serial,
  output wire             rx_serial,
  input  wire             serial_in,
  output wire             serial_out,
  input  wire             cts_n,
  input  wire             dsr_n,
  input  wire             ri_n,
  input  wire             dcd_n,
  output wire             dtr_n,
  output wire             rts_n,
  output wire             general_output_1,
  output wire             general_output_2,
  output wire             irq_pending,
  output reg              sleep_active,
  output wire             irda_mode,
  output wire             xon_any,
  output wire             cts_rts_flow_en,
  output wire             prescale_sel,
  output wire [7:0]       prescale_val
);

  // ------------------------------
  // registers
  // ------------------------------
  reg [7:0]       irq_enable_reg;
  reg [7:0]       modem_control;
  reg [7:0]       enhanced_feature_reg;
  reg [7:0]       additional_control_reg;
  reg [7:0]       nine_bit_mode_reg;
  reg [7:0]       clock_prescaler_reg;
  reg             fifo_en;
  reg [LVL_W-1:0] rx_trig;
  reg [LVL_W-1:0] tx_trig;
  reg [3:0]       line_err;
  reg             data_err;
  reg [3:0]       msr_delta;
  reg [3:0]       modem_prev;
  reg             modem_valid;
  reg             tout_flag;
  reg [2:0]       tout_cnt;
  reg             thr_flag;
  reg             thr_cond_prev;
  reg             spec_flag;
  reg             cr_flag;
  reg             cts_n_prev;
  reg             rts_n_prev;
  reg [5:0]       rd_code;

  // ------------------------------
  // apb decode
  // ------------------------------
  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr     = access & pwrite;
  wire rd     = access & ~pwrite;

  function mapped;
    input [7:0] a;
    begin
      if (a == `UISM_OFF_IER || a == `UISM_OFF_ISR || a == `UISM_OFF_MCR)
        mapped = 1'b1;
      else if (a == `UISM_OFF_LSR || a == `UISM_OFF_MSR || a == `UISM_OFF_EFR)
        mapped = 1'b1;
      else if (a == `UISM_OFF_ACR || a == `UISM_OFF_NMR || a == `UISM_OFF_CPR)
        mapped = 1'b1;
      else if (a == `UISM_OFF_CFG || a == `UISM_OFF_RTL || a == `UISM_OFF_TTL)
        mapped = 1'b1;
      else
        mapped = 1'b0;
    end
  endfunction

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped(paddr);

  wire rd_isr = rd & (paddr == `UISM_OFF_ISR);
  wire rd_lsr = rd & (paddr == `UISM_OFF_LSR);
  wire rd_msr = rd & (paddr == `UISM_OFF_MSR);

  // ------------------------------
  // modes
  // ------------------------------
  wire enh      = enhanced_feature_reg[`UISM_EFR_ENH];
  wire nine     = nine_bit_mode_reg[`UISM_NMR_NINE];
  wire loopback = modem_control[`UISM_MCR_LOOP];

  assign irda_mode       = enh & modem_control[`UISM_MCR_IRDA]; // R19
  assign xon_any         = enh & modem_control[`UISM_MCR_XANY]; // R18
  assign cts_rts_flow_en = ~enh & modem_control[`UISM_MCR_XANY]; // R18
  assign prescale_sel    = modem_control[`UISM_MCR_PRESC]; // R20
  assign prescale_val    = clock_prescaler_reg;

  // ------------------------------
  // modem pins and loopback
  // ------------------------------
  assign dtr_n            = loopback | ~modem_control[0]; // R14 R16
  assign rts_n            = loopback | ~modem_control[1]; // R14 R16
  assign general_output_1 = loopback | modem_control[2]; // R15 R16
  assign general_output_2 = loopback | modem_control[3]; // R15 R16
  assign serial_out       = loopback | tx_serial; // R16
  assign rx_serial        = loopback ? tx_serial : serial_in; // R16

  // active-high modem state: cts, dsr, ri, dcd
  wire [3:0] modem_now = loopback ?
    {modem_control[3], modem_control[2], modem_control[0], modem_control[1]} :
    {~dcd_n, ~ri_n, ~dsr_n, ~cts_n}; // R16 R22

  // ri# low-to-high is active-high ri falling
  wire [3:0] delta_evt = {modem_now[3] ^ modem_prev[3],
                          modem_prev[2] & ~modem_now[2],
                          modem_now[1] ^ modem_prev[1],
                          modem_now[0] ^ modem_prev[0]} & {4{modem_valid}}; // R21

  wire [7:0] modem_status = {modem_now[3], modem_now[2], modem_now[1], modem_now[0],
                             msr_delta[3], msr_delta[2], msr_delta[1], msr_delta[0]}; // R22

  // ------------------------------
  // interrupt sources
  // ------------------------------
  // line_err: {break, framing, parity, overrun}
  wire lvl1_norm = irq_enable_reg[`UISM_IER_RLS] & (|line_err); // R01
  wire lvl1_nine = (irq_enable_reg[`UISM_IER_MS] & (line_err[0] | line_err[2] | line_err[3]))
                 | (nine_bit_mode_reg[`UISM_NMR_ADDR] & line_err[1]); // R02
  wire src1  = nine ? lvl1_nine : lvl1_norm;
  wire src2a = irq_enable_reg[`UISM_IER_RDA] & (rx_level > rx_trig); // R03
  wire src2b = irq_enable_reg[`UISM_IER_RDA] & tout_flag; // R04
  wire src3  = irq_enable_reg[`UISM_IER_THR] & thr_flag; // R05
  wire src4  = irq_enable_reg[`UISM_IER_MS] & (|msr_delta); // R07 R17
  wire src5  = enh & irq_enable_reg[`UISM_IER_SPEC] & spec_flag; // R08
  wire src6  = enh & cr_flag; // R09

  reg [5:0] ident;
  always @* begin
    if (src1)
      ident = `UISM_ID_RLS;
    else if (src2a)
      ident = `UISM_ID_RDA;
    else if (src2b)
      ident = `UISM_ID_TOUT;
    else if (src3)
      ident = `UISM_ID_THR;
    else if (src4)
      ident = `UISM_ID_MS;
    else if (src5)
      ident = `UISM_ID_SPEC;
    else if (src6)
      ident = `UISM_ID_CTSRTS;
    else
      ident = `UISM_ID_NONE; // R23
  end

  assign irq_pending = ~ident[0];

  // transmit empty condition; trigger zero with enhanced triggers waits for
  // the shifter and the line as well, so the last stop bit is not cut short
  wire trig_zero = additional_control_reg[`UISM_ACR_TRIG] && (tx_trig == {LVL_W{1'b0}});
  wire thr_cond  = trig_zero ?
    (tx_level == {LVL_W{1'b0}}) & tx_shift_empty & tx_serial : (tx_level < tx_trig); // R06

  // cts/rts rising at the pins; in non-enhanced mode both masks are on
  wire cts_rise = ~cts_n_prev & cts_n & (~enh | irq_enable_reg[`UISM_IER_CTS]);
  wire rts_rise = ~rts_n_prev & rts_n & (~enh | irq_enable_reg[`UISM_IER_RTS]);

  wire spec_evt = xoff_evt | (enhanced_feature_reg[`UISM_EFR_SPEC] & second_stop_char_evt)
                | (nine & special_evt); // R08

  // ------------------------------
  // sleep
  // ------------------------------
  wire sleep_req = enh ? irq_enable_reg[`UISM_IER_SLEEP] : irq_enable_reg[`UISM_IER_SPEC];
  wire sleep_ok  = sleep_req & ~irda_mode
                 & (tx_level == {LVL_W{1'b0}}) & tx_shift_empty
                 & rx_serial & rx_idle & (rx_level == {LVL_W{1'b0}})
                 & ~loopback & (msr_delta == 4'h0) & ~irq_pending; // R10 R12 R13

  // ------------------------------
  // read data mux
  // ------------------------------
  wire [7:0] lsr_val = {data_err,
                        tx_shift_empty & (tx_level == {LVL_W{1'b0}}),
                        tx_level == {LVL_W{1'b0}},
                        line_err,
                        rx_level != {LVL_W{1'b0}}};
  wire [7:0] ier_val = sleep_req ?
    (enh ? {irq_enable_reg[7:5], sleep_active, irq_enable_reg[3:0]}
         : {irq_enable_reg[7:6], sleep_active, irq_enable_reg[4:0]}) :
    irq_enable_reg; // R11

  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (paddr == `UISM_OFF_IER)
      rd_val = ier_val;
    else if (paddr == `UISM_OFF_ISR)
      rd_val = {fifo_en, fifo_en, ident};
    else if (paddr == `UISM_OFF_MCR)
      rd_val = modem_control;
    else if (paddr == `UISM_OFF_LSR)
      rd_val = lsr_val;
    else if (paddr == `UISM_OFF_MSR)
      rd_val = modem_status;
    else if (paddr == `UISM_OFF_EFR)
      rd_val = enhanced_feature_reg;
    else if (paddr == `UISM_OFF_ACR)
      rd_val = additional_control_reg;
    else if (paddr == `UISM_OFF_NMR)
      rd_val = nine_bit_mode_reg;
    else if (paddr == `UISM_OFF_CPR)
      rd_val = clock_prescaler_reg;
    else if (paddr == `UISM_OFF_CFG)
      rd_val = {7'h00, fifo_en};
    else if (paddr == `UISM_OFF_RTL)
      rd_val = rx_trig[7:0];
    else if (paddr == `UISM_OFF_TTL)
      rd_val = tx_trig[7:0];
  end

  // ------------------------------
  // register writes and bus data
  // ------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                 <= 32'h00000000;
      rd_code                <= 6'h01;
      irq_enable_reg         <= 8'h00;
      modem_control          <= 8'h00;
      enhanced_feature_reg   <= 8'h00;
      additional_control_reg <= 8'h00;
      nine_bit_mode_reg      <= 8'h00;
      clock_prescaler_reg    <= `UISM_CPR_RESET; // R20
      fifo_en                <= 1'b0;
      rx_trig                <= {LVL_W{1'b0}};
      tx_trig                <= {LVL_W{1'b0}};
    end else begin
      // read data is latched in setup so it is a flop by the access cycle
      if (setup) begin
        prdata  <= {24'h000000, rd_val};
        rd_code <= ident;
      end
      if (wr) begin
        if (paddr == `UISM_OFF_IER)
          irq_enable_reg <= pwdata[7:0];
        else if (paddr == `UISM_OFF_MCR)
          modem_control <= enh ? pwdata[7:0]
                               : {modem_control[7:6], pwdata[5:0]}; // R18 R19 R20
        else if (paddr == `UISM_OFF_EFR)
          enhanced_feature_reg <= pwdata[7:0];
        else if (paddr == `UISM_OFF_ACR)
          additional_control_reg <= pwdata[7:0];
        else if (paddr == `UISM_OFF_NMR)
          nine_bit_mode_reg <= pwdata[7:0];
        else if (paddr == `UISM_OFF_CPR && enh)
          clock_prescaler_reg <= pwdata[7:0]; // R20
        else if (paddr == `UISM_OFF_CFG)
          fifo_en <= pwdata[`UISM_CFG_FIFO];
        else if (paddr == `UISM_OFF_RTL)
          rx_trig <= pwdata[LVL_W-1:0];
        else if (paddr == `UISM_OFF_TTL)
          tx_trig <= pwdata[LVL_W-1:0];
      end
    end
  end

  // ------------------------------
  // status flags: a set in the same cycle as a clear always wins
  // ------------------------------
  wire [3:0] err_evt = {break_evt, framing_evt, parity_evt, overrun_evt};
  wire       derr_evt = framing_evt | break_evt | (~nine & parity_evt); // R02

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_err      <= 4'h0;
      data_err      <= 1'b0;
      msr_delta     <= 4'h0;
      modem_prev    <= 4'h0;
      modem_valid   <= 1'b0;
      thr_flag      <= 1'b0;
      thr_cond_prev <= 1'b0;
      spec_flag     <= 1'b0;
      cr_flag       <= 1'b0;
      cts_n_prev    <= 1'b1;
      rts_n_prev    <= 1'b1;
      sleep_active  <= 1'b0;
    end else begin
      line_err <= (rd_lsr ? 4'h0 : line_err) | err_evt; // R01
      data_err <= (rd_lsr ? 1'b0 : data_err) | derr_evt; // R02
      // first cycle after reset only primes the previous-state copy
      modem_prev  <= modem_now;
      modem_valid <= 1'b1;
      msr_delta   <= (rd_msr ? 4'h0 : msr_delta) | delta_evt; // R07 R21
      thr_cond_prev <= thr_cond;
      if (thr_cond & ~thr_cond_prev)
        thr_flag <= 1'b1; // R05 R06
      else if ((rd_isr && rd_code == `UISM_ID_THR) || tx_level > tx_trig)
        thr_flag <= 1'b0; // R05
      if (enh & spec_evt)
        spec_flag <= 1'b1; // R08
      else if (rd_isr && rd_code == `UISM_ID_SPEC)
        spec_flag <= 1'b0;
      cts_n_prev <= cts_n;
      rts_n_prev <= rts_n;
      if (enh & (cts_rise | rts_rise))
        cr_flag <= 1'b1; // R09
      else if (rd_isr && rd_code == `UISM_ID_CTSRTS)
        cr_flag <= 1'b0;
      sleep_active <= sleep_ok; // R10 R11 R12
    end
  end

  // ------------------------------
  // receive time-out
  // ------------------------------
  // rx_push marks the stop-bit centre of the newest item, so counting
  // character ticks from it measures the idle gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_cnt  <= 3'h0;
      tout_flag <= 1'b0;
    end else begin
      if (rx_push | rx_read | ~fifo_en)
        tout_cnt <= 3'h0;
      else if (char_tick && tout_cnt != `UISM_TOUT_CHARS)
        tout_cnt <= tout_cnt + 3'h1;
      if (rx_read | ~fifo_en)
        tout_flag <= 1'b0; // R04
      else if (tout_cnt == `UISM_TOUT_CHARS && rx_level != {LVL_W{1'b0}})
        tout_flag <= 1'b1; // R04
    end
  end

endmodule

// *** tb/uism_modem_model.sv ***
/*
 * far-side modem model: drives the modem status lines and the serial input.
 * assumes the bench moves the lines through set_lines right after a clock edge.
 */
`timescale 1ns/1ns
module uism_modem_model (
  input  wire  pclk,
  input  wire  dtr_n,
  input  wire  rts_n,
  input  wire  serial_out,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n,
  output logic serial_in
);
  // ------------------------------
  // line drivers
  // ------------------------------
  // lines rest inactive high, as on a pulled-up cable with no modem activity
  initial {cts_n, dsr_n, ri_n, dcd_n, serial_in} = 5'h1F;
  // a start bit on serial_in is how the far side wakes a sleeping channel
  task automatic set_lines(input logic [4:0] v);
    {cts_n, dsr_n, ri_n, dcd_n, serial_in} <= v;
  endtask
endmodule

// *** tb/uism_ctrl_properties.sv ***
/*
 * checker for the channel control block: port-level relations over time.
 * assumes it is bound into every instance of the control block.
 */
`timescale 1ns/1ns
module uism_ctrl_properties #(
  parameter LVL_W = 8
) (
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire [7:0]       paddr,
  input wire             pready,
  input wire             pslverr,
  input wire [LVL_W-1:0] rx_level,
  input wire [LVL_W-1:0] tx_level,
  input wire             rx_idle,
  input wire             tx_shift_empty,
  input wire             tx_serial,
  input wire             rx_serial,
  input wire             serial_in,
  input wire             serial_out,
  input wire             dtr_n,
  input wire             rts_n,
  input wire             general_output_1,
  input wire             general_output_2,
  input wire             irq_pending,
  input wire             sleep_active,
  input wire             irda_mode,
  input wire             xon_any,
  input wire             cts_rts_flow_en,
  input wire [7:0]       prescale_val
);
  // ------------------------------
  // relations
  // ------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // loopback and modem-flag conditions are internal, so only the port-visible part
  wire quiet = rx_level == 0 && tx_level == 0 && tx_shift_empty && rx_idle && serial_in
               && !irq_pending;
  sequence s_asleep_disturbed;
    sleep_active && (rx_level != 0 || !serial_in);
  endsequence
  a_bus_ready: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  a_unmapped_err: assert property (psel && penable && paddr == 8'h3C |-> pslverr)
    else $error("unmapped access not refused");
  a_loop_route: assert property ((serial_out != tx_serial) |-> rx_serial == tx_serial
    && dtr_n && rts_n && general_output_1 && general_output_2)
    else $error("loopback routing wrong");
  a_sleep_entry: assert property ($rose(sleep_active) |-> $past(quiet))
    else $error("sleep entered while channel busy");
  a_sleep_no_ir: assert property (sleep_active |-> !$past(irda_mode))
    else $error("sleep while infrared mode");
  a_wake_on_data: assert property (s_asleep_disturbed |=> !sleep_active)
    else $error("sleep kept after activity");
  a_presc_reset: assert property ($rose(presetn) |-> prescale_val == 8'h20)
    else $error("prescaler reset value wrong");
  a_flow_exclusive: assert property (!(xon_any && cts_rts_flow_en))
    else $error("bit five decoded both ways");
endmodule

bind uism_ctrl uism_ctrl_properties #(.LVL_W(LVL_W)) u_props (.*);

// *** tb/tb.sv ***
/*
 * bench for the channel interrupt, sleep and modem control block.
 * assumes the modem model file and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
`include "uism_regs.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, rx_level, tx_level, prescale_val;
  logic [31:0] pwdata, prdata, rdv;
  logic [9:0]  ev;
  logic        rx_idle, tx_shift_empty, tx_serial, rx_serial, serial_in, serial_out;
  logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, go1, go2, irq_pending;
  logic        sleep_active, irda_mode, xon_any, flow_en, prescale_sel;
  int          fail_count = 0;
  int          n_checks = 0;

  uism_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_level, .tx_level, .rx_push(ev[4]), .rx_read(ev[5]),
    .char_tick(ev[6]), .rx_idle, .tx_shift_empty, .overrun_evt(ev[0]), .parity_evt(ev[1]),
    .framing_evt(ev[2]), .break_evt(ev[3]), .xoff_evt(ev[7]), .second_stop_char_evt(ev[8]),
    .special_evt(ev[9]), .tx_serial, .rx_serial, .serial_in, .serial_out, .cts_n, .dsr_n,
    .ri_n, .dcd_n, .dtr_n, .rts_n, .general_output_1(go1), .general_output_2(go2),
    .irq_pending, .sleep_active, .irda_mode, .xon_any, .cts_rts_flow_en(flow_en),
    .prescale_sel, .prescale_val);
  uism_modem_model modem (.pclk, .dtr_n, .rts_n, .serial_out, .cts_n, .dsr_n, .ri_n,
    .dcd_n, .serial_in);

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  // ------------------------------
  // bus and check helpers
  // ------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fail_count++;
    rdv = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, {24'h0, e});
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'h1;
    @(posedge pclk);
    ev[b] <= 1'h0;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset;
    rdchk(`UISM_OFF_CPR, 8'h20);
    wr(`UISM_OFF_CPR, 8'h55);
    rdchk(`UISM_OFF_CPR, 8'h20);
    rdchk(`UISM_OFF_MSR, 8'h00);
    rd(8'h3C);
    chk({rdv[30:0], err}, 32'h1);
    chk({dtr_n, rts_n, go1, go2}, 4'hC);
    $display("reset test done");
  endtask
  task automatic t_mcr;
    for (int i = 0; i < 16; i++) begin
      wr(`UISM_OFF_MCR, i[7:0]);
      @(posedge pclk);
      chk({dtr_n, rts_n, go1, go2}, {~i[0], ~i[1], i[2], i[3]});
    end
    wr(`UISM_OFF_EFR, 8'h10);
    wr(`UISM_OFF_CPR, 8'h55);
    wr(`UISM_OFF_MCR, 8'hA0);
    @(posedge pclk);
    chk({prescale_sel, xon_any, flow_en, prescale_val}, {3'h6, 8'h55});
    wr(`UISM_OFF_EFR, 8'h00);
    @(posedge pclk);
    chk({xon_any, flow_en}, 2'h1);
    wr(`UISM_OFF_EFR, 8'h10);
    wr(`UISM_OFF_MCR, 8'h00);
    wr(`UISM_OFF_EFR, 8'h00);
    $display("control test done");
  endtask
  task automatic t_loop;
    wr(`UISM_OFF_MCR, 8'h10);
    rd(`UISM_OFF_MSR);
    tx_serial <= 1'h0;
    // external modem lines all active, serial input high: loopback must ignore them
    modem.set_lines(5'h01);
    wr(`UISM_OFF_MCR, 8'h13);
    @(posedge pclk);
    chk({serial_out, rx_serial, dtr_n, rts_n, go1, go2}, 6'h2F);
    rdchk(`UISM_OFF_MSR, 8'h33);
    wr(`UISM_OFF_MCR, 8'h1C);
    rdchk(`UISM_OFF_MSR, 8'hCB);
    wr(`UISM_OFF_MCR, 8'h10);
    rdchk(`UISM_OFF_MSR, 8'h0C);
    modem.set_lines(5'h1F);
    tx_serial <= 1'h1;
    wr(`UISM_OFF_MCR, 8'h00);
    rd(`UISM_OFF_MSR);
    $display("loopback test done");
  endtask
  task automatic t_mstat;
    wr(`UISM_OFF_IER, 8'h08);
    modem.set_lines(5'h0F);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'h00);
    rdchk(`UISM_OFF_MSR, 8'h11);
    rdchk(`UISM_OFF_ISR, 8'h01);
    modem.set_lines(5'h0B);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_MSR, 8'h50);
    modem.set_lines(5'h1F);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_MSR, 8'h05);
    wr(`UISM_OFF_IER, 8'h00);
    $display("modem status test done");
  endtask
  task automatic t_rx;
    wr(`UISM_OFF_IER, 8'h01);
    wr(`UISM_OFF_RTL, 8'h02);
    rx_level <= 8'h02;
    pulse(1);
    rdchk(`UISM_OFF_ISR, 8'h01);
    rd(`UISM_OFF_LSR);
    rx_level <= 8'h03;
    wr(`UISM_OFF_IER, 8'h05);
    rdchk(`UISM_OFF_ISR, 8'h04);
    pulse(2);
    @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'h06);
    rd(`UISM_OFF_LSR);
    rdchk(`UISM_OFF_ISR, 8'h04);
    rx_level <= 8'h00;
    wr(`UISM_OFF_IER, 8'h00);
    $display("receive test done");
  endtask
  task automatic t_tx;
    wr(`UISM_OFF_TTL, 8'h04);
    tx_level <= 8'h05;
    wr(`UISM_OFF_IER, 8'h02);
    tx_level <= 8'h03;
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'h02);
    rdchk(`UISM_OFF_ISR, 8'h01);
    tx_level <= 8'h05;
    @(posedge pclk);
    tx_level <= 8'h03;
    repeat (2) @(posedge pclk);
    tx_level <= 8'h05;
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'h01);
    // a zero trigger also waits for the shifter
    wr(`UISM_OFF_TTL, 8'h00);
    wr(`UISM_OFF_ACR, 8'h20);
    {tx_shift_empty, tx_level} <= 9'h000;
    rdchk(`UISM_OFF_ISR, 8'h01);
    tx_shift_empty <= 1'h1;
    rdchk(`UISM_OFF_ISR, 8'h02);
    wr(`UISM_OFF_IER, 8'h00);
    $display("transmit test done");
  endtask
  task automatic t_tout;
    wr(`UISM_OFF_CFG, 8'h01);
    wr(`UISM_OFF_RTL, 8'h08);
    wr(`UISM_OFF_IER, 8'h01);
    rx_level <= 8'h01;
    pulse(4);
    repeat (3) pulse(6);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'hC1);
    pulse(6);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'hCC);
    pulse(5);
    @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'hC1);
    rx_level <= 8'h00;
    wr(`UISM_OFF_IER, 8'h00);
    $display("timeout test done");
  endtask
  task automatic t_sleep;
    wr(`UISM_OFF_EFR, 8'h10);
    rd(`UISM_OFF_MSR);
    wr(`UISM_OFF_IER, 8'h10);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_IER, 8'h10);
    chk(prescale_val, 8'h55);
    modem.set_lines(5'h1E);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_IER, 8'h00);
    modem.set_lines(5'h1F);
    rx_idle <= 1'h0;
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_IER, 8'h00);
    rx_idle <= 1'h1;
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_IER, 8'h10);
    wr(`UISM_OFF_MCR, 8'h40);
    repeat (2) @(posedge pclk);
    rdchk(`UISM_OFF_IER, 8'h00);
    wr(`UISM_OFF_MCR, 8'h00);
    wr(`UISM_OFF_IER, 8'h20);
    repeat (2) @(posedge pclk);
    chk(sleep_active, 1'h0);
    pulse(7);
    @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'hD0);
    rdchk(`UISM_OFF_ISR, 8'hC1);
    wr(`UISM_OFF_EFR, 8'h00);
    pulse(8);
    @(posedge pclk);
    rdchk(`UISM_OFF_ISR, 8'hC1);
    $display("sleep test done");
  endtask
  // ------------------------------
  // run control
  // ------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_level, tx_level, ev} = '0;
    {rx_idle, tx_shift_empty, tx_serial} = 3'h7;
    presetn = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_mcr;
    t_loop;
    t_mstat;
    t_rx;
    t_tx;
    t_tout;
    t_sleep;
    tally_and_finish;
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish;
  end
endmodule
